//--- rtl/gpga_arbiter.sv
// Core-logic grant arbiter for a point-to-point graphics port built on PCI.
// Assumes port pins are asynchronous and core-logic requests share clk.
//
// How it works
// - Arbiter may withdraw the grant any clock.
// - After withdrawal, wait out the start window.
// - Withdrawn early: two dead clocks before regrant. Code counts a four-clock blackout, so five dead clocks.
// - Next driver inserts turnaround; target for reads.
// - Read grant on next-to-last read data phase.
// - Count write grants; issue only below four.
// - No request grant during an active enqueue.
// - Low-priority read only when buffer not full.
// - After enqueue, REQ# must rise then drop.
// - Regrant after FRAME# or two quiet clocks. Code waits out the four-clock blackout instead of two clocks.
// - Status code valid only while granted.
`include "gpga_consts.svh"
`default_nettype none

module gpga_arbiter #(
    parameter int WR_MAX = 4
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Port pins from the master, active low
    input  wire logic       reqN,
    input  wire logic       frameN,
    input  wire logic       irdyN,
    input  wire logic       enqStrobeN,
    input  wire logic       readBufferFullN,
    // Port grant pins to the master
    output logic            gntN,
    output logic [2:0]      grantStatusCode,
    // Core-logic data return requests
    input  wire logic       rdDataReq,
    input  wire logic       rdLowPriority,
    input  wire logic       rdActive,
    input  wire logic       rdNextToLast,
    input  wire logic       wrDataReq,
    input  wire logic       wrLowPriority,
    // Core-logic grant feedback
    output logic            rdGranted,
    output logic            wrGranted,
    output logic [2:0]      wrOutstanding,
    output logic [2:0]      busType
);

    // ============================================================
    // Pin synchronisation
    logic [4:0] pinSync;
    logic       reqAct;
    logic       frameAct;
    logic       irdyAct;
    logic       enqAct;
    logic       bufNotFull;

    gpga_sync #(
        .WIDTH   (5),
        .RST_VAL (`GPGA_PIN_RST)
    ) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .pinIn   ({reqN, frameN, irdyN, enqStrobeN, readBufferFullN}),
        .pinSync (pinSync)
    );

    // Active-high views of the synchronised pins
    assign reqAct     = ~pinSync[4];
    assign frameAct   = ~pinSync[3];
    assign irdyAct    = ~pinSync[2];
    assign enqAct     = ~pinSync[1];
    assign bufNotFull =  pinSync[0];

    // ============================================================
    // State
    gpga_pkg::gpga_txn_e curType_ff;
    gpga_pkg::gpga_txn_e nxt_curType;
    logic [1:0]          idleCnt_ff;
    logic [1:0]          nxt_idleCnt;
    logic                framePrev_ff;
    logic                irdyPrev_ff;
    logic                enqPrev_ff;
    logic                gntN_ff;
    logic                nxt_gntN;
    logic [2:0]          status_ff;
    logic [2:0]          nxt_status;
    logic                reqGrantOn_ff;
    logic                nxt_reqGrantOn;
    logic [1:0]          holdCnt_ff;
    logic [1:0]          nxt_holdCnt;
    logic [2:0]          blackCnt_ff;
    logic [2:0]          nxt_blackCnt;
    logic                reqArm_ff;
    logic                nxt_reqArm;
    gpga_pkg::gpga_cnt_t wrOut_ff;
    gpga_pkg::gpga_cnt_t nxt_wrOut;
    logic                rdGranted_ff;
    logic                wrGranted_ff;

    // Edge events seen on the synchronised pins
    logic frameRise;
    logic irdyRise;
    logic enqRise;
    logic startSeen;
    logic busIdle;
    logic rdGrantNow;
    logic wrGrantNow;

    assign frameRise = frameAct & ~framePrev_ff;
    assign irdyRise  = irdyAct & ~irdyPrev_ff;
    assign enqRise   = enqAct & ~enqPrev_ff;
    assign startSeen = frameRise | enqRise;
    assign busIdle   = ~frameAct & ~irdyAct & ~enqAct;

    // ============================================================
    // Bus state tracker
    // Type follows the last start or data grant seen; idle clocks saturate at three.
    always_comb
    begin
        nxt_curType = curType_ff;
        nxt_idleCnt = busIdle ? ((idleCnt_ff == `GPGA_IDLE_SAT) ? idleCnt_ff
                                                                : idleCnt_ff + 2'h1)
                              : 2'h0;
        if (frameRise)
        begin
            nxt_curType = gpga_pkg::GPGA_PCI;
        end
        else if (enqRise)
        begin
            nxt_curType = gpga_pkg::GPGA_ENQ;
        end
        else if (rdGrantNow)
        begin
            nxt_curType = gpga_pkg::GPGA_RDDATA;
        end
        else if (wrGrantNow)
        begin
            nxt_curType = gpga_pkg::GPGA_WRDATA;
        end
        else if (busIdle && !rdActive && (wrOut_ff == 3'h0))
        begin
            nxt_curType = gpga_pkg::GPGA_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            curType_ff   <= gpga_pkg::GPGA_IDLE;
            idleCnt_ff   <= 2'h0;
            framePrev_ff <= 1'b0;
            irdyPrev_ff  <= 1'b0;
            enqPrev_ff   <= 1'b0;
        end
        else
        begin
            curType_ff   <= nxt_curType;
            idleCnt_ff   <= nxt_idleCnt;
            framePrev_ff <= frameAct;
            irdyPrev_ff  <= irdyAct;
            enqPrev_ff   <= enqAct;
        end
    end

    // ============================================================
    // Grant eligibility
    logic reqGrantOk;
    logic canRd;
    logic canWr;

    // Read data: wait for the next-to-last phase of a read in flight,
    // so the grant is first sampled on its last 1x clock.
    // The target (this side) owns the read turnaround clock.
    assign canRd = rdDataReq
                 & (~rdLowPriority | bufNotFull)
                 & (~rdActive | rdNextToLast);

    // Write data: bounded so the master's tracker never overflows
    assign canWr = wrDataReq & (wrOut_ff < 3'(WR_MAX));

    // Request: armed, out of the start window, no enqueue running.
    // A frame or enqueue start, or four clocks of countdown, clears the blackout.
    assign reqGrantOk = reqAct
                      & reqArm_ff
                      & (blackCnt_ff == 3'h0)
                      & ~enqAct
                      & (curType_ff != gpga_pkg::GPGA_ENQ);

    // Fixed priority: read, then write, then request
    assign rdGrantNow = canRd;
    assign wrGrantNow = canWr & ~canRd;

    // ============================================================
    // Grant driver
    // Data grants are single-clock pulses; a start grant is held for
    // a short time and then withdrawn, which trades master latency for
    // freedom from deadlock.
    always_comb
    begin
        nxt_gntN       = 1'b1;
        nxt_status     = `GPGA_ST_IDLE;
        nxt_reqGrantOn = 1'b0;
        nxt_holdCnt    = 2'h0;
        nxt_blackCnt   = (blackCnt_ff == 3'h0) ? 3'h0 : blackCnt_ff - 3'h1;
        if (startSeen)
        begin
            nxt_blackCnt = 3'h0;
        end
        if (rdGrantNow)
        begin
            nxt_gntN   = 1'b0;
            nxt_status = rdLowPriority ? `GPGA_ST_RD_LP : `GPGA_ST_RD_HP;
        end
        else if (wrGrantNow)
        begin
            nxt_gntN   = 1'b0;
            nxt_status = wrLowPriority ? `GPGA_ST_WR_LP : `GPGA_ST_WR_HP;
        end
        else if (reqGrantOn_ff && !startSeen && holdCnt_ff < `GPGA_REQ_HOLD)
        begin
            nxt_gntN       = 1'b0;
            nxt_status     = `GPGA_ST_START;
            nxt_reqGrantOn = 1'b1;
            nxt_holdCnt    = holdCnt_ff + 2'h1;
        end
        else if (!reqGrantOn_ff && reqGrantOk)
        begin
            nxt_gntN       = 1'b0;
            nxt_status     = `GPGA_ST_START;
            nxt_reqGrantOn = 1'b1;
        end
        // Withdrawal without a seen start: cover the enqueue window
        // plus the pin synchroniser lag before granting again.
        if (reqGrantOn_ff && !nxt_reqGrantOn && !startSeen)
        begin
            nxt_blackCnt = `GPGA_ENQ_WIN + `GPGA_SYNC_LAG;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gntN_ff       <= 1'b1;
            status_ff     <= `GPGA_ST_IDLE;
            reqGrantOn_ff <= 1'b0;
            holdCnt_ff    <= 2'h0;
            blackCnt_ff   <= `GPGA_BLACK_RST;
        end
        else
        begin
            gntN_ff       <= nxt_gntN;
            status_ff     <= nxt_status;
            reqGrantOn_ff <= nxt_reqGrantOn;
            holdCnt_ff    <= nxt_holdCnt;
            blackCnt_ff   <= nxt_blackCnt;
        end
    end

    // ============================================================
    // Request re-arm after an enqueue
    // An enqueue keeps REQ# low without meaning a new request, so the
    // next start grant waits for REQ# to be seen high then low again.
    // REQ# high in the strobe's own clock marks a single request and
    // already counts, else a single enqueue would never be regranted.
    always_comb
    begin
        nxt_reqArm = reqArm_ff;
        if (!reqAct)
        begin
            nxt_reqArm = 1'b1;
        end
        else if (enqRise)
        begin
            nxt_reqArm = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reqArm_ff <= 1'b1;
        end
        else
        begin
            reqArm_ff <= nxt_reqArm;
        end
    end

    // ============================================================
    // Outstanding write-grant counter
    // Up on each write grant, down on each IRDY# assertion while nonzero; both in
    // one clock leave a nonzero count unchanged.
    always_comb
    begin
        nxt_wrOut = wrOut_ff;
        if (wrGrantNow && !(irdyRise && wrOut_ff != 3'h0))
        begin
            nxt_wrOut = wrOut_ff + 3'h1;
        end
        else if (!wrGrantNow && irdyRise && wrOut_ff != 3'h0)
        begin
            nxt_wrOut = wrOut_ff - 3'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrOut_ff     <= `GPGA_WR_RST;
            rdGranted_ff <= 1'b0;
            wrGranted_ff <= 1'b0;
        end
        else
        begin
            wrOut_ff     <= nxt_wrOut;
            rdGranted_ff <= rdGrantNow;
            wrGranted_ff <= wrGrantNow;
        end
    end

    // ============================================================
    // Outputs, all straight from flops
    assign gntN            = gntN_ff;
    assign grantStatusCode = status_ff;
    assign rdGranted       = rdGranted_ff;
    assign wrGranted       = wrGranted_ff;
    assign wrOutstanding   = wrOut_ff;
    assign busType         = curType_ff;

endmodule

`default_nettype wire

//--- rtl/gpga_consts.svh
// Constants for the graphics port grant arbiter: status codes, limits, windows.
// Assumes inclusion by bare name from the arbiter and its package users.
`ifndef GPGA_CONSTS_SVH
`define GPGA_CONSTS_SVH

// ============================================================
// Grant status codes, meaningful only while the grant is low
`define GPGA_ST_START    3'h7
`define GPGA_ST_RD_LP    3'h0
`define GPGA_ST_RD_HP    3'h1
`define GPGA_ST_WR_LP    3'h2
`define GPGA_ST_WR_HP    3'h3
`define GPGA_ST_IDLE     3'h7

// ============================================================
// Limits and windows, in 1x clocks
`define GPGA_WR_MAX      3'h4
`define GPGA_PCI_WIN     3'h1
`define GPGA_ENQ_WIN     3'h2
`define GPGA_SYNC_LAG    3'h2
`define GPGA_REQ_HOLD    2'h1
`define GPGA_IDLE_SAT    2'h3

// ============================================================
// Reset values
`define GPGA_PIN_RST     5'h1f
`define GPGA_WR_RST      3'h0
`define GPGA_BLACK_RST   3'h0

`endif

//--- rtl/gpga_pkg.sv
// Types shared by the graphics port grant arbiter.
// Assumes the constants header is compiled alongside.
`default_nettype none

package gpga_pkg;

    // ============================================================
    // Kind of transaction currently owning the port
    typedef enum logic [2:0]
    {
        GPGA_IDLE   = 3'b000,
        GPGA_PCI    = 3'b001,
        GPGA_ENQ    = 3'b010,
        GPGA_RDDATA = 3'b011,
        GPGA_WRDATA = 3'b100
    } gpga_txn_e;

    // Width of the outstanding write-grant counter
    typedef logic [2:0] gpga_cnt_t;

endpackage

`default_nettype wire

//--- rtl/gpga_sync.sv
// Two-flop synchroniser for a group of port pins.
// Assumes the pins are asynchronous to clk; reset sets the deasserted level.
`default_nettype none

module gpga_sync #(
    parameter int               WIDTH   = 5,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Pins in, synchronised copy out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // ============================================================
    // First stage feeds only the second, to contain metastability
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end
        else
        begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign pinSync = stage2_ff;

endmodule

`default_nettype wire

//--- tb/gpga_arbiter_sva.sv
// Checker for the grant arbiter: grant pins, status codes and write count.
// Assumes it is bound onto gpga_arbiter and sees only that module's ports.
`default_nettype none

module gpga_arbiter_sva #(
    parameter int WR_MAX = 4
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // Port pins
    input wire logic       frameN,
    input wire logic       enqStrobeN,
    input wire logic       readBufferFullN,
    input wire logic       gntN,
    input wire logic [2:0] grantStatusCode,
    // Core side
    input wire logic       rdDataReq,
    input wire logic       rdActive,
    input wire logic       rdNextToLast,
    input wire logic       rdGranted,
    input wire logic       wrGranted,
    input wire logic [2:0] wrOutstanding
);
    // ============================================================
    // Helpers
    logic       startG;
    logic [3:0] quietCnt_ff;
    logic [3:0] nxt_quietCnt;

    // Start grant visible on the pins
    assign startG = !gntN && grantStatusCode == 3'h7;

    // Clocks with no start on the pins; saturates so it never wraps
    always_comb
    begin
        nxt_quietCnt = quietCnt_ff;
        if (!frameN || !enqStrobeN)
            nxt_quietCnt = 4'h0;
        else if (quietCnt_ff != 4'hf)
            nxt_quietCnt = quietCnt_ff + 4'h1;
    end

    // Register the quiet count
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            quietCnt_ff <= 4'h0;
        else
            quietCnt_ff <= nxt_quietCnt;
    end

    // ============================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_CODE_IDLE: assert property (gntN |-> grantStatusCode == 3'h7)
        else $error("status code not idle while grant is high");
    AST_RD_CODE: assert property (rdGranted |-> !gntN && grantStatusCode[2:1] == 2'b00)
        else $error("read grant without read code");
    AST_WR_CODE: assert property (wrGranted |-> !gntN && grantStatusCode[2:1] == 2'b01)
        else $error("write grant without write code");
    AST_RD_PHASE: assert property (rdGranted |-> $past(rdDataReq)
        && (!$past(rdActive) || $past(rdNextToLast)))
        else $error("read grant outside next-to-last phase");
    AST_LP_RBF: assert property (rdGranted && grantStatusCode == 3'h0
        |-> $past(readBufferFullN, 2) || $past(readBufferFullN, 3) || $past(readBufferFullN, 4))
        else $error("low priority read granted while buffer full");
    AST_WR_MAX: assert property (wrOutstanding <= WR_MAX)
        else $error("write grants above limit");
    AST_WR_STEP: assert property (wrGranted |-> wrOutstanding == $past(wrOutstanding) + 3'h1
        || wrOutstanding == $past(wrOutstanding))
        else $error("write count did not follow grant");
    AST_WR_NOSTEP: assert property (!wrGranted |-> wrOutstanding <= $past(wrOutstanding))
        else $error("write count rose without grant");
    AST_BLACKOUT: assert property ($past(startG) && gntN && quietCnt_ff >= 4'h8
        |=> (!startG) [*3])
        else $error("start regranted inside start window");
endmodule

bind gpga_arbiter gpga_arbiter_sva #(.WR_MAX(WR_MAX)) chk (
    .clk(clk), .arst_n(arst_n), .frameN(frameN), .enqStrobeN(enqStrobeN),
    .readBufferFullN(readBufferFullN), .gntN(gntN), .grantStatusCode(grantStatusCode),
    .rdDataReq(rdDataReq), .rdActive(rdActive), .rdNextToLast(rdNextToLast),
    .rdGranted(rdGranted), .wrGranted(wrGranted), .wrOutstanding(wrOutstanding));

`default_nettype wire

//--- tb/gpga_master_model.sv
// Graphics master model: request pin, PCI start and enqueue strobe.
// Assumes the bench drives want, kind and slow; IRDY# is driven by the bench.
`default_nettype none

module gpga_master_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Bench control: kind 1 PCI, 2 enqueue, 0 never starts
    input  wire logic       want,
    input  wire logic [1:0] kind,
    input  wire logic       slow,
    // Grant pins
    input  wire logic       gntN,
    input  wire logic [2:0] grantStatusCode,
    // Master pins
    output logic            reqN,
    output logic            frameN,
    output logic            enqStrobeN
);
    logic [1:0] waitCnt;
    logic       idle;

    // Bus idle and no strobe pending
    assign idle = frameN && enqStrobeN && waitCnt == 2'h0;

    // Grant sampled only at the edge; a vanished grant gives no start
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reqN       <= 1'b1;
            frameN     <= 1'b1;
            enqStrobeN <= 1'b1;
            waitCnt    <= 2'h0;
        end
        else
        begin
            frameN     <= 1'b1;
            enqStrobeN <= 1'b1;
            reqN       <= !want;
            if (waitCnt != 2'h0)
                waitCnt <= waitCnt - 2'h1;
            if (waitCnt == 2'h1)
            begin
                enqStrobeN <= 1'b0;
                reqN       <= 1'b1; // Single request raises REQ# for a clock
            end
            if (!gntN && grantStatusCode == 3'h7 && want && idle && !reqN)
            begin
                if (kind == 2'h1)
                begin
                    frameN <= 1'b0;
                    reqN   <= 1'b1;
                end
                else if (kind == 2'h2)
                begin
                    if (slow)
                        waitCnt <= 2'h1; // One clock late, the latest allowed
                    else
                    begin
                        enqStrobeN <= 1'b0; // Strobe seen on the next clock
                        reqN       <= 1'b1; // Single request
                    end
                end
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the grant arbiter with a master model.
// Assumes the checker is bound onto the arbiter and a 200 MHz clock.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Signals
    localparam int WR_MAX = 4;
    logic        clk             = 1'b0;
    logic        arst_n          = 1'b0;
    logic        irdyN           = 1'b1;
    logic        readBufferFullN = 1'b1;
    logic        rdDataReq       = 1'b0;
    logic        rdLowPriority   = 1'b0;
    logic        rdActive        = 1'b0;
    logic        rdNextToLast    = 1'b0;
    logic        wrDataReq       = 1'b0;
    logic        wrLowPriority   = 1'b0;
    logic        want            = 1'b0;
    logic [1:0]  kind            = 2'h0;
    logic        slow            = 1'b0;
    logic [31:0] seed            = 32'h5ee5_be8d;
    logic        reqN, frameN, enqStrobeN, gntN, rdGranted, wrGranted;
    logic [2:0]  grantStatusCode, wrOutstanding, busType;
    int          miscompares = 0, checked = 0;
    int          rdCnt = 0, wrCnt = 0, lpCnt = 0, hpCnt = 0, stCnt = 0;
    int          gapRun = 0, minGap = 999;
    logic        startNow, startPrev = 1'b0;

    // 5 ns period
    always #2.5 clk = ~clk;

    gpga_arbiter #(.WR_MAX(WR_MAX)) uut (
        .clk(clk), .arst_n(arst_n), .reqN(reqN), .frameN(frameN), .irdyN(irdyN),
        .enqStrobeN(enqStrobeN), .readBufferFullN(readBufferFullN), .gntN(gntN),
        .grantStatusCode(grantStatusCode), .rdDataReq(rdDataReq),
        .rdLowPriority(rdLowPriority), .rdActive(rdActive), .rdNextToLast(rdNextToLast),
        .wrDataReq(wrDataReq), .wrLowPriority(wrLowPriority), .rdGranted(rdGranted),
        .wrGranted(wrGranted), .wrOutstanding(wrOutstanding), .busType(busType));

    gpga_master_model master (
        .clk(clk), .arst_n(arst_n), .want(want), .kind(kind), .slow(slow), .gntN(gntN),
        .grantStatusCode(grantStatusCode), .reqN(reqN), .frameN(frameN),
        .enqStrobeN(enqStrobeN));

    // ============================================================
    // Helpers
    function logic rnd_bit();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[0];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // One IRDY# assertion, spaced wide enough to clear the pin synchroniser
    task automatic irdy_pulse();
        irdyN = 1'b0;
        tick(1);
        irdyN = 1'b1;
        tick(7);
    endtask

    task automatic close_out();
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Grant event counters and shortest gap between start grants,
    // sampled mid-cycle so registered outputs have settled
    always @(negedge clk)
    begin
        startNow = gntN === 1'b0 && grantStatusCode === 3'h7;
        rdCnt += int'(rdGranted === 1'b1);
        wrCnt += int'(wrGranted === 1'b1);
        lpCnt += int'(rdGranted === 1'b1 && grantStatusCode === 3'h0);
        hpCnt += int'(rdGranted === 1'b1 && grantStatusCode === 3'h1);
        if (startNow && !startPrev)
        begin
            stCnt++;
            if (gapRun < minGap)
                minGap = gapRun;
        end
        gapRun = startNow ? 0 : gapRun + 1;
        startPrev = startNow;
    end

    // Watchdog sized well past the few hundred clocks the tests need
    initial
    begin
        #60000;
        miscompares++;
        close_out();
    end

    // ============================================================
    // Scenarios
    initial
    begin
        int base;
        tick(3);
        arst_n = 1'b1;
        tick(2);
        // Writes stop at the limit; each IRDY# frees exactly one slot
        wrLowPriority = rnd_bit();
        wrDataReq = 1'b1; // Bench as master accepts every queued grant
        tick(20);
        chk("wrGrants", WR_MAX, wrCnt);
        chk("wrOutstanding", WR_MAX, {29'h0, wrOutstanding});
        for (int i = 0; i < 3; i++)
            irdy_pulse();
        chk("wrGrants", WR_MAX + 3, wrCnt);
        wrDataReq = 1'b0;
        repeat (WR_MAX)
            irdy_pulse();
        chk("wrOutstanding", 0, {29'h0, wrOutstanding});
        chk("busTypeIdle", 32'(gpga_pkg::GPGA_IDLE), {29'h0, busType});
        // Low priority reads held off while the read buffer is full
        readBufferFullN = 1'b0;
        tick(2); // Full level must clear the pin synchroniser first
        rdLowPriority = 1'b1;
        rdDataReq = 1'b1;
        base = rdCnt;
        tick(20);
        chk("lpReadGrants", base, rdCnt);
        readBufferFullN = 1'b1;
        tick(10);
        chk("lpReadFlowing", 1, lpCnt > 0);
        readBufferFullN = 1'b0;
        rdLowPriority = 1'b0;
        base = hpCnt;
        tick(10);
        chk("hpReadFlowing", 1, hpCnt > base);
        // During a read return only the next-to-last phase may grant
        rdActive = 1'b1;
        tick(6);
        base = rdCnt;
        tick(10);
        chk("rdMidTransfer", base, rdCnt);
        rdNextToLast = 1'b1;
        tick(1);
        rdNextToLast = 1'b0;
        tick(5);
        chk("rdNextToLast", base + 1, rdCnt);
        rdDataReq = 1'b0;
        rdActive = 1'b0;
        // Master never starts: each withdrawal opens a dead window
        want = 1'b1;
        tick(8);
        minGap = 999;
        base = stCnt;
        tick(40);
        chk("startGap", 1, minGap >= 5);
        chk("startRepeats", 1, stCnt >= base + 2);
        want = 1'b0;
        tick(8);
        // PCI start then enqueue start, each followed by a fresh request
        for (int k = 1; k < 3; k++)
        begin
            kind = k[1:0];
            slow = rnd_bit();
            base = stCnt;
            want = 1'b1;
            tick(30);
            want = 1'b0;
            chk("regrantAfterStart", 1, stCnt >= base + 2);
            tick(8);
        end
        close_out();
    end
endmodule

`default_nettype wire
